// ==== rtl/acs_column_clock_select.v ====
// analog column clock selector: aux clock muxes, column muxes, /4
// assumes all clock sources are synchronous levels sampled at ref_clk_in
// Overview of operation
// R01 - aux clock a picks one of eight blocks
// R02 - aux clock b has its own select
// R03 - each column muxes four candidate sources
// R04 - two-bit select field per column
// R05 - column clock is source divided by four
// R06 - one divided clock feeds whole column
// R07 - select 0,1 system; 2,3 aux a,b
`timescale 1ns/1ps
`include "acs_clk_regs.vh"

module acs_column_clock_select (
  input  wire       ref_clk_in,
  input  wire       nrst_in,
  input  wire [7:0] dig_blk_clk_in,
  input  wire       sys_clk_src_a_in,
  input  wire       sys_clk_src_b_in,
  input  wire [5:0] aux_clock_select_reg_in,
  input  wire [7:0] column_clock_select_reg_in,
  output reg        aux_analog_clk_a_out,
  output reg        aux_analog_clk_b_out,
  output wire       column_clk_0_out,
  output wire       column_clk_1_out,
  output wire       column_clk_2_out,
  output wire       column_clk_3_out
);

  // ------------------------------------------------------------------
  // select fields
  // ------------------------------------------------------------------
  wire [2:0] aux_a_sel;
  wire [2:0] aux_b_sel;
  wire [1:0] col_sel_0;
  wire [1:0] col_sel_1;
  wire [1:0] col_sel_2;
  wire [1:0] col_sel_3;
  wire       aux_a_d;
  wire       aux_b_d;
  wire [3:0] col_clk;

  assign aux_a_sel = aux_clock_select_reg_in[`ACS_AUX_A_MSB:`ACS_AUX_A_LSB];
  assign aux_b_sel = aux_clock_select_reg_in[`ACS_AUX_B_MSB:`ACS_AUX_B_LSB];
  assign col_sel_0 = column_clock_select_reg_in[`ACS_COL0_MSB:`ACS_COL0_LSB];
  assign col_sel_1 = column_clock_select_reg_in[`ACS_COL1_MSB:`ACS_COL1_LSB];
  assign col_sel_2 = column_clock_select_reg_in[`ACS_COL2_MSB:`ACS_COL2_LSB];
  assign col_sel_3 = column_clock_select_reg_in[`ACS_COL3_MSB:`ACS_COL3_LSB];

  // ------------------------------------------------------------------
  // auxiliary clock source muxes
  // ------------------------------------------------------------------
  acs_blk_clk_mux #(
    .NUM_SRC     (`ACS_NUM_DIG_BLKS),
    .SEL_W       (`ACS_AUX_SEL_W)
  ) u_aux_a_mux (
    .blk_clk_in  (dig_blk_clk_in),
    .sel_in      (aux_a_sel),
    .clk_out     (aux_a_d)
  );

  acs_blk_clk_mux #(
    .NUM_SRC     (`ACS_NUM_DIG_BLKS),
    .SEL_W       (`ACS_AUX_SEL_W)
  ) u_aux_b_mux (
    .blk_clk_in  (dig_blk_clk_in),
    .sel_in      (aux_b_sel),
    .clk_out     (aux_b_d)
  );

  // ------------------------------------------------------------------
  // auxiliary clock registers
  // ------------------------------------------------------------------
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aux_analog_clk_a_out <= `ACS_OUT_RST;
      aux_analog_clk_b_out <= `ACS_OUT_RST;
    end else begin
      aux_analog_clk_a_out <= aux_a_d; // R01
      aux_analog_clk_b_out <= aux_b_d; // R02
    end
  end

  // ------------------------------------------------------------------
  // per column source mux and divider
  // ------------------------------------------------------------------
  acs_column_divider #(
    .HALF_CNT     (`ACS_DIV_HALF)
  ) u_col0_div (
    .ref_clk_in   (ref_clk_in),
    .nrst_in      (nrst_in),
    .src_sel_in   (col_sel_0), // R04
    .sys_a_in     (sys_clk_src_a_in),
    .sys_b_in     (sys_clk_src_b_in),
    .aux_a_in     (aux_analog_clk_a_out),
    .aux_b_in     (aux_analog_clk_b_out),
    .col_clk_out  (col_clk[0])
  );

  acs_column_divider #(
    .HALF_CNT     (`ACS_DIV_HALF)
  ) u_col1_div (
    .ref_clk_in   (ref_clk_in),
    .nrst_in      (nrst_in),
    .src_sel_in   (col_sel_1), // R04
    .sys_a_in     (sys_clk_src_a_in),
    .sys_b_in     (sys_clk_src_b_in),
    .aux_a_in     (aux_analog_clk_a_out),
    .aux_b_in     (aux_analog_clk_b_out),
    .col_clk_out  (col_clk[1])
  );

  acs_column_divider #(
    .HALF_CNT     (`ACS_DIV_HALF)
  ) u_col2_div (
    .ref_clk_in   (ref_clk_in),
    .nrst_in      (nrst_in),
    .src_sel_in   (col_sel_2), // R04
    .sys_a_in     (sys_clk_src_a_in),
    .sys_b_in     (sys_clk_src_b_in),
    .aux_a_in     (aux_analog_clk_a_out),
    .aux_b_in     (aux_analog_clk_b_out),
    .col_clk_out  (col_clk[2])
  );

  acs_column_divider #(
    .HALF_CNT     (`ACS_DIV_HALF)
  ) u_col3_div (
    .ref_clk_in   (ref_clk_in),
    .nrst_in      (nrst_in),
    .src_sel_in   (col_sel_3), // R04
    .sys_a_in     (sys_clk_src_a_in),
    .sys_b_in     (sys_clk_src_b_in),
    .aux_a_in     (aux_analog_clk_a_out),
    .aux_b_in     (aux_analog_clk_b_out),
    .col_clk_out  (col_clk[3])
  );

  // ------------------------------------------------------------------
  // column clock outputs
  // ------------------------------------------------------------------
  // single divided clock per column, fanned out to its blocks
  assign column_clk_0_out = col_clk[0]; // R06
  assign column_clk_1_out = col_clk[1]; // R06
  assign column_clk_2_out = col_clk[2]; // R06
  assign column_clk_3_out = col_clk[3]; // R06

endmodule // acs_column_clock_select

// --------------------------------------------------------------------
// one of n block clock mux
// --------------------------------------------------------------------
// sel width must cover every source: no out of range read
module acs_blk_clk_mux #(
  parameter NUM_SRC = 8,
  parameter SEL_W   = 3
) (
  input  wire [NUM_SRC-1:0] blk_clk_in,
  input  wire [SEL_W-1:0]   sel_in,
  output wire               clk_out
);

  assign clk_out = blk_clk_in[sel_in];

endmodule // acs_blk_clk_mux

// --------------------------------------------------------------------
// column source mux and divide by four
// --------------------------------------------------------------------
// divider phase is kept across select changes
module acs_column_divider #(
  parameter [`ACS_DIV_W-1:0] HALF_CNT = `ACS_DIV_HALF
) (
  input  wire       ref_clk_in,
  input  wire       nrst_in,
  input  wire [1:0] src_sel_in,
  input  wire       sys_a_in,
  input  wire       sys_b_in,
  input  wire       aux_a_in,
  input  wire       aux_b_in,
  output reg        col_clk_out
);

  reg                   src_d;
  reg                   src_q;
  reg  [`ACS_DIV_W-1:0] cnt_q;
  wire                  src_rise;

  // ------------------------------------------------------------------
  // column source mux
  // ------------------------------------------------------------------
  always @* begin
    case (src_sel_in) // R03
      `ACS_SRC_SYS_A: src_d = sys_a_in; // R07
      `ACS_SRC_SYS_B: src_d = sys_b_in;
      `ACS_SRC_AUX_A: src_d = aux_a_in;
      `ACS_SRC_AUX_B: src_d = aux_b_in;
      default:        src_d = sys_a_in;
    endcase
  end

  // ------------------------------------------------------------------
  // rising edge of the sampled source
  // ------------------------------------------------------------------
  // a source faster than half ref clock loses edges
  assign src_rise = src_d & ~src_q;

  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      src_q <= `ACS_OUT_RST;
    end else begin
      src_q <= src_d;
    end
  end

  // ------------------------------------------------------------------
  // divide by four
  // ------------------------------------------------------------------
  // toggle on every second source rise: output at f/4
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q       <= `ACS_DIV_CNT_RST;
      col_clk_out <= `ACS_OUT_RST;
    end else if (src_rise) begin
      if (cnt_q == HALF_CNT) begin // R05
        cnt_q       <= `ACS_DIV_CNT_RST;
        col_clk_out <= ~col_clk_out;
      end else begin
        cnt_q <= cnt_q + `ACS_DIV_CNT_STEP;
      end
    end
  end

endmodule // acs_column_divider

// ==== rtl/acs_clk_regs.vh ====
// field layout and reset values of the analog column clock selector
// assumes inclusion by rtl files that build the column clock logic
`ifndef ACS_CLK_REGS_VH
`define ACS_CLK_REGS_VH

// --------------------------------------------------------------------
// aux clock select register fields
// --------------------------------------------------------------------
`define ACS_AUX_A_LSB      0
`define ACS_AUX_A_MSB      2
`define ACS_AUX_B_LSB      3
`define ACS_AUX_B_MSB      5
`define ACS_AUX_REG_W      6
`define ACS_AUX_REG_RST    6'h00

// --------------------------------------------------------------------
// column clock select register fields
// --------------------------------------------------------------------
`define ACS_COL_FIELD_W    2
`define ACS_COL_REG_W      8
`define ACS_COL_REG_RST    8'h00
`define ACS_NUM_COLS       4
`define ACS_NUM_DIG_BLKS   8
`define ACS_AUX_SEL_W      3
`define ACS_COL0_LSB       0
`define ACS_COL0_MSB       1
`define ACS_COL1_LSB       2
`define ACS_COL1_MSB       3
`define ACS_COL2_LSB       4
`define ACS_COL2_MSB       5
`define ACS_COL3_LSB       6
`define ACS_COL3_MSB       7

// --------------------------------------------------------------------
// column source encoding
// --------------------------------------------------------------------
`define ACS_SRC_SYS_A      2'h0
`define ACS_SRC_SYS_B      2'h1
`define ACS_SRC_AUX_A      2'h2
`define ACS_SRC_AUX_B      2'h3

// --------------------------------------------------------------------
// divider
// --------------------------------------------------------------------
`define ACS_DIV_W          2
`define ACS_DIV_HALF       2'h1
`define ACS_DIV_CNT_RST    2'h0
`define ACS_DIV_CNT_STEP   2'h1
`define ACS_OUT_RST        1'h0

`endif

// ==== verification/acs_column_clock_select_monitor.sv ====
// checker on the column clock selector ports
// assumes a bind onto acs_column_clock_select
`timescale 1ns/1ps
module acs_monitor (
  input wire       ref_clk_in,
  input wire       nrst_in,
  input wire       sys_clk_src_a_in,
  input wire       sys_clk_src_b_in,
  input wire [7:0] dig_blk_clk_in,
  input wire [7:0] column_clock_select_reg_in,
  input wire [5:0] aux_clock_select_reg_in,
  input wire       aux_analog_clk_a_out,
  input wire       aux_analog_clk_b_out,
  input wire       column_clk_0_out,
  input wire       column_clk_1_out,
  input wire       column_clk_2_out,
  input wire       column_clk_3_out
);
  wire [7:0] s = column_clock_select_reg_in;
  wire [5:0] x = aux_clock_select_reg_in;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  property p_aux_a;
    $past(nrst_in) && $stable(x) |->
      aux_analog_clk_a_out == $past(dig_blk_clk_in[x[2:0]]);
  endproperty
  a_aux_a: assert property (p_aux_a) else $error("aux a wrong");
  property p_aux_b;
    $past(nrst_in) && $stable(x) |->
      aux_analog_clk_b_out == $past(dig_blk_clk_in[x[5:3]]);
  endproperty
  a_aux_b: assert property (p_aux_b) else $error("aux b wrong");
  property p_hold;
    $changed(column_clk_0_out) |=> $stable(column_clk_0_out)[*3];
  endproperty
  a_hold: assert property (p_hold) else $error("col too fast");
  property p_idle0;
    (s[1:0] == 2'h0 && !sys_clk_src_a_in)[*4] |-> $stable(column_clk_0_out);
  endproperty
  a_idle0: assert property (p_idle0) else $error("col0 moved");
  property p_idle1;
    (s[3:2] == 2'h1 && !sys_clk_src_b_in)[*4] |-> $stable(column_clk_1_out);
  endproperty
  a_idle1: assert property (p_idle1) else $error("col1 moved");
  property p_idle2;
    (s[5:4] == 2'h2 && !aux_analog_clk_a_out)[*4] |->
      $stable(column_clk_2_out);
  endproperty
  a_idle2: assert property (p_idle2) else $error("col2 moved");
  property p_idle3;
    (s[7:6] == 2'h3 && !aux_analog_clk_b_out)[*4] |->
      $stable(column_clk_3_out);
  endproperty
  a_idle3: assert property (p_idle3) else $error("col3 moved");
  c_col0: cover property ($rose(column_clk_0_out));
  c_col3: cover property ($rose(column_clk_3_out));
  c_aux: cover property ($rose(aux_analog_clk_a_out));
endmodule // acs_monitor
bind acs_column_clock_select acs_monitor mon (
  .ref_clk_in                 (ref_clk_in),
  .nrst_in                    (nrst_in),
  .sys_clk_src_a_in           (sys_clk_src_a_in),
  .sys_clk_src_b_in           (sys_clk_src_b_in),
  .dig_blk_clk_in             (dig_blk_clk_in),
  .column_clock_select_reg_in (column_clock_select_reg_in),
  .aux_clock_select_reg_in    (aux_clock_select_reg_in),
  .aux_analog_clk_a_out       (aux_analog_clk_a_out),
  .aux_analog_clk_b_out       (aux_analog_clk_b_out),
  .column_clk_0_out           (column_clk_0_out),
  .column_clk_1_out           (column_clk_1_out),
  .column_clk_2_out           (column_clk_2_out),
  .column_clk_3_out           (column_clk_3_out)
);

// ==== verification/acs_col_blocks.sv ====
// column analog blocks; assumes one column clock input
`timescale 1ns/1ps
module acs_col_blocks (
  input  wire clk_in,
  output int  rises_out
);
  int n = 0;
  always @(posedge clk_in) n <= n + 1;
  assign rises_out = n;
endmodule // acs_col_blocks

// ==== verification/analog_column_clock_select_tb.sv ====
// bench for the column clock selector; assumes rtl and checker compiled
`timescale 1ns/1ps
module analog_column_clock_select_tb;
  reg ref_clk_in = 0, nrst_in = 0, sa = 0, sb = 0, ea, eb;
  reg [7:0] dig = 0, csel = 0;
  reg [5:0] asel = 0;
  wire ao, bo;
  wire [3:0] col;
  int rises [4];
  int er [4];
  bit pv [4];
  reg [7:0] nd;
  reg na, nb, v;
  int mismatches = 0, checks = 0, seed = 49, cyc = 0, k, c, m;
  always #20 ref_clk_in = ~ref_clk_in;
  acs_column_clock_select dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .dig_blk_clk_in(dig), .sys_clk_src_a_in(sa), .sys_clk_src_b_in(sb),
    .aux_clock_select_reg_in(asel), .column_clock_select_reg_in(csel),
    .aux_analog_clk_a_out(ao), .aux_analog_clk_b_out(bo),
    .column_clk_0_out(col[0]), .column_clk_1_out(col[1]),
    .column_clk_2_out(col[2]), .column_clk_3_out(col[3]));
  for (genvar g = 0; g < 4; g++) begin : blk
    acs_col_blocks u (.clk_in(col[g]), .rises_out(rises[g]));
  end
  task chk(string nm, logic [7:0] e, logic [7:0] s);
    checks++;
    if (e !== s) begin
      mismatches++;
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, s);
    end
  endtask
  task step(bit t);
    @(negedge ref_clk_in);
    ea = dig[asel[2:0]];
    eb = dig[asel[5:3]];
    nd = t ? dig + 8'h01 : 8'h00;
    na = t & ~sa;
    nb = t & ~sb;
    for (m = 0; m < 4; m++) begin
      case (csel[2*m+:2])
        2'h0: v = na;
        2'h1: v = nb;
        2'h2: v = nd[asel[2:0]];
        default: v = nd[asel[5:3]];
      endcase
      if (v && !pv[m]) er[m]++;
      pv[m] = v;
    end
    @(posedge ref_clk_in);
    dig <= nd;
    sa <= na;
    sb <= nb;
    #1 chk("aux_a", ea, ao);
    chk("aux_b", eb, bo);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk_in) if (++cyc > 1000) begin
    mismatches++;
    summarize;
  end
  initial begin
    repeat (20) @(posedge ref_clk_in);
    nrst_in <= 1;
    for (k = 0; k < 4; k++) begin
      asel <= 6'($random(seed));
      csel <= {2'(k + 3), 2'(k + 2), 2'(k + 1), 2'(k)};
      repeat (8) step(0);
      repeat (80) step(1);
      repeat (8) step(0);
      for (c = 0; c < 4; c++)
        chk("col_rises", (er[c] + 2) / 4, rises[c]);
      $display("test %0d done", k);
    end
    summarize;
  end
endmodule // analog_column_clock_select_tb
